// >>> scope_trig_pkg.sv
package scope_trig_pkg;

  localparam int DW = 16;
  localparam int AW = 8;
  localparam int RW = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_HOLDOFF = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_AVG_COUNT = 8'h10;
  localparam logic [7:0] OFS_SHOT_COUNT = 8'h14;
  localparam logic [7:0] OFS_LOST_COUNT = 8'h18;

  // control fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SRC_W = 4;
  localparam int CTRL_SLOPE_BIT = 4;
  localparam int CTRL_TRIG_EN_BIT = 5;
  localparam int CTRL_AVG_RST_BIT = 8;

  // status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LOSS_BIT = 2;
  localparam int STAT_LAST_BAD_BIT = 3;

  localparam int LEVEL_W = 8;
  localparam int HOLD_W = 24;
  localparam int CNT_W = 16;

  // threshold counts per percent of full scale
  localparam logic signed [9:0] FS_PER_PCT = 10'sd327;
  localparam int SHOT_LEN = 16;
  localparam int FIFO_DEPTH = 8;

  // reset values
  localparam logic [3:0] CTRL_SRC_RST = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
  localparam int HOLD_RST_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [HOLD_W-1:0] HOLD_RST_CYC =
    HOLD_W'((HOLD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    SRC_OFF = 4'h0, SRC_CONT = 4'h1,
    SRC_IN1 = 4'h2, SRC_IN2 = 4'h3,
    SRC_OUT1 = 4'h4, SRC_OUT2 = 4'h5,
    SRC_OSC1 = 4'h6, SRC_OSC2 = 4'h7, SRC_OSC3 = 4'h8, SRC_OSC4 = 4'h9,
    SRC_OSC5 = 4'ha, SRC_OSC6 = 4'hb, SRC_OSC7 = 4'hc, SRC_OSC8 = 4'hd,
    SRC_DIG0 = 4'he, SRC_DIG1 = 4'hf
  } trig_src_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ARMED = 2'b01,
    ST_CAPTURE = 2'b11,
    ST_HOLDOFF = 2'b10
  } acq_state_e;

  typedef logic signed [DW-1:0] sample_t;

  typedef struct packed {
    sample_t [7:0] osc;
    sample_t [1:0] sig_out;
    sample_t [1:0] sig_in;
  } analog_src_s;

  typedef struct packed {
    logic last;
    sample_t data;
  } shot_word_s;

endpackage

// >>> shot_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module shot_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> scope_shot_trigger_control.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module scope_shot_trigger_control
  import scope_trig_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [AW-1:0] ADDR,
  input wire logic [RW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [RW-1:0] RDATA,
  input wire analog_src_s ANALOG,
  input wire logic SRC_VALID,
  input wire logic [1:0] DIGITAL_LINE,
  input wire sample_t SCOPE_DATA,
  input wire logic SCOPE_VALID,
  output shot_word_s SHOT_DATA,
  output logic SHOT_VALID,
  input wire logic SHOT_READY,
  output logic ACTIVITY,
  output logic SHOT_INVALID,
  output logic ACQ_ON
);

  acq_state_e state_q;
  acq_state_e state_d;
  trig_src_e src_q;
  logic slope_rise_q;
  logic trig_en_q;
  logic signed [LEVEL_W-1:0] level_q;
  logic [HOLD_W-1:0] holdoff_q;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [$clog2(SHOT_LEN)-1:0] samp_cnt_q;
  logic loss_q;
  logic loss_flag_q;
  logic last_bad_q;
  logic [CNT_W-1:0] avg_cnt_q;
  logic [CNT_W-1:0] shot_cnt_q;
  logic [CNT_W-1:0] lost_cnt_q;
  logic [1:0] dig_s1_q;
  logic [1:0] dig_s2_q;
  logic opp_seen_q;
  logic activity_q;
  logic invalid_q;
  logic [RW-1:0] rdata_q;

  logic wr_ctrl;
  logic wr_level;
  logic wr_hold;
  logic wr_status;
  logic avg_rst;
  sample_t src_sample;
  logic src_is_dig;
  logic eval;
  logic above;
  logic signed [DW+1:0] thresh;
  logic on_sel_side;
  logic trig_hit;
  logic free_run;
  logic start;
  logic beat;
  logic beat_last;
  logic drop;
  logic shot_end;
  logic shot_bad;
  logic hold_done;
  shot_word_s fifo_in;
  logic fifo_in_ready;

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign wr_level = WR && (ADDR == OFS_LEVEL);
  assign wr_hold = WR && (ADDR == OFS_HOLDOFF);
  assign wr_status = WR && (ADDR == OFS_STATUS);
  assign avg_rst = wr_ctrl && WDATA[CTRL_AVG_RST_BIT];

  // configuration registers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      src_q <= SRC_OFF;
      slope_rise_q <= 1'b1;
      trig_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      src_q <= trig_src_e'(WDATA[CTRL_SRC_LSB +: CTRL_SRC_W]);
      slope_rise_q <= WDATA[CTRL_SLOPE_BIT];
      trig_en_q <= WDATA[CTRL_TRIG_EN_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      level_q <= LEVEL_RST;
    end else if (wr_level) begin
      level_q <= WDATA[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      holdoff_q <= HOLD_RST_CYC;
    end else if (wr_hold) begin
      holdoff_q <= WDATA[HOLD_W-1:0];
    end
  end

  // digital line synchroniser
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      dig_s1_q <= 2'h0;
      dig_s2_q <= 2'h0;
    end else begin
      dig_s1_q <= DIGITAL_LINE;
      dig_s2_q <= dig_s1_q;
    end
  end

  // source selection
  always_comb begin
    src_sample = '0;
    src_is_dig = 1'b0;
    above = 1'b0;
    case (src_q)
      SRC_IN1, SRC_IN2: begin
        src_sample = ANALOG.sig_in[1'(src_q - SRC_IN1)];
      end
      SRC_OUT1, SRC_OUT2: begin
        src_sample = ANALOG.sig_out[1'(src_q - SRC_OUT1)];
      end
      SRC_OSC1, SRC_OSC2, SRC_OSC3, SRC_OSC4,
      SRC_OSC5, SRC_OSC6, SRC_OSC7, SRC_OSC8: begin
        src_sample = ANALOG.osc[3'(src_q - SRC_OSC1)];
      end
      SRC_DIG0, SRC_DIG1: begin
        src_is_dig = 1'b1;
        above = dig_s2_q[1'(src_q - SRC_DIG0)];
      end
      default: begin
        src_sample = '0;
      end
    endcase
    if (!src_is_dig) begin
      above = ((DW+2)'(src_sample) >= thresh);
    end
  end

  // signed threshold from percent
  assign thresh = (DW+2)'(level_q) * (DW+2)'(FS_PER_PCT);

  assign eval = src_is_dig || SRC_VALID;
  assign on_sel_side = slope_rise_q ? above : !above;

  // opposite side must be seen while armed
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      opp_seen_q <= 1'b0;
    end else if (state_q != ST_ARMED) begin
      opp_seen_q <= 1'b0;
    end else if (eval && !on_sel_side) begin
      opp_seen_q <= 1'b1;
    end
  end

  assign trig_hit = eval && opp_seen_q && on_sel_side;
  assign free_run = (src_q == SRC_CONT) || !trig_en_q;
  assign start = (state_q == ST_ARMED) && (free_run || trig_hit);

  // shot data path
  assign beat = (state_q == ST_CAPTURE) && SCOPE_VALID;
  assign beat_last = beat && (samp_cnt_q == ($clog2(SHOT_LEN))'(SHOT_LEN-1));
  assign drop = beat && !fifo_in_ready;
  assign shot_end = beat_last;
  assign shot_bad = loss_q || drop;
  assign hold_done = (hold_cnt_q == '0);
  assign fifo_in.last = beat_last;
  assign fifo_in.data = SCOPE_DATA;

  // acquisition state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (src_q != SRC_OFF) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (shot_end) begin
          state_d = ST_HOLDOFF;
        end
      end
      ST_HOLDOFF: begin
        if (hold_done) begin
          state_d = ST_ARMED;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (src_q == SRC_OFF) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // holdoff countdown
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hold_cnt_q <= '0;
    end else if (shot_end) begin
      hold_cnt_q <= holdoff_q;
    end else if (state_q == ST_HOLDOFF && !hold_done) begin
      hold_cnt_q <= hold_cnt_q - 1'b1;
    end
  end

  // sample counter and loss tracking per shot
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      samp_cnt_q <= '0;
      loss_q <= 1'b0;
    end else if (start) begin
      samp_cnt_q <= '0;
      loss_q <= 1'b0;
    end else if (beat) begin
      samp_cnt_q <= samp_cnt_q + 1'b1;
      if (drop) begin
        loss_q <= 1'b1;
      end
    end
  end

  // activity and invalid pulses
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      activity_q <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      activity_q <= start;
      invalid_q <= shot_end && shot_bad;
    end
  end

  // sticky loss flag, set wins over clear
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      loss_flag_q <= 1'b0;
    end else if (shot_end && shot_bad) begin
      loss_flag_q <= 1'b1;
    end else if (wr_status && WDATA[STAT_LOSS_BIT]) begin
      loss_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      last_bad_q <= 1'b0;
    end else if (shot_end) begin
      last_bad_q <= shot_bad;
    end
  end

  // averaged-shot counter, good shots only
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      avg_cnt_q <= '0;
    end else if (avg_rst) begin
      avg_cnt_q <= (shot_end && !shot_bad) ? CNT_W'(1) : '0;
    end else if (shot_end && !shot_bad && avg_cnt_q != '1) begin
      avg_cnt_q <= avg_cnt_q + 1'b1;
    end
  end

  // total and lost shot counters
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      shot_cnt_q <= '0;
      lost_cnt_q <= '0;
    end else begin
      if (start) begin
        shot_cnt_q <= shot_cnt_q + 1'b1;
      end
      if (shot_end && shot_bad) begin
        lost_cnt_q <= lost_cnt_q + 1'b1;
      end
    end
  end

  // register read, one cycle latency
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= '0;
    end else if (RD) begin
      rdata_q <= '0;
      case (ADDR)
        OFS_CTRL: begin
          rdata_q[CTRL_SRC_LSB +: CTRL_SRC_W] <= src_q;
          rdata_q[CTRL_SLOPE_BIT] <= slope_rise_q;
          rdata_q[CTRL_TRIG_EN_BIT] <= trig_en_q;
        end
        OFS_LEVEL: begin
          rdata_q <= RW'(level_q);
        end
        OFS_HOLDOFF: begin
          rdata_q[HOLD_W-1:0] <= holdoff_q;
        end
        OFS_STATUS: begin
          rdata_q[STAT_STATE_LSB +: 2] <= state_q;
          rdata_q[STAT_LOSS_BIT] <= loss_flag_q;
          rdata_q[STAT_LAST_BAD_BIT] <= last_bad_q;
        end
        OFS_AVG_COUNT: begin
          rdata_q[CNT_W-1:0] <= avg_cnt_q;
        end
        OFS_SHOT_COUNT: begin
          rdata_q[CNT_W-1:0] <= shot_cnt_q;
        end
        OFS_LOST_COUNT: begin
          rdata_q[CNT_W-1:0] <= lost_cnt_q;
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  shot_fifo #(
    .WIDTH($bits(shot_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .nrst(NRST),
    .in_data(fifo_in),
    .in_valid(beat),
    .in_ready(fifo_in_ready),
    .out_data(SHOT_DATA),
    .out_valid(SHOT_VALID),
    .out_ready(SHOT_READY)
  );

  assign RDATA = rdata_q;
  assign ACTIVITY = activity_q;
  assign SHOT_INVALID = invalid_q;
  assign ACQ_ON = (state_q != ST_OFF);

endmodule
`default_nettype wire

// >>> scope_trig_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module scope_trig_monitor
  import scope_trig_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic WR,
  input wire logic RD,
  input wire logic [RW-1:0] RDATA,
  input wire logic ACTIVITY,
  input wire logic SHOT_INVALID,
  input wire logic ACQ_ON
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  chk_off_no_act: assert property (!ACQ_ON |=> !ACTIVITY)
    else $error("shot started while off");
  chk_stay_off: assert property (!ACQ_ON && !WR && !$past(WR) |=> !ACQ_ON)
    else $error("acquisition on without config");
  chk_act_gap: assert property (ACTIVITY |=> !ACTIVITY [*8])
    else $error("shots too close");
  chk_act_on: assert property (ACTIVITY |-> ACQ_ON)
    else $error("activity outside acquisition");
  chk_inv_pulse: assert property (SHOT_INVALID |=> !SHOT_INVALID)
    else $error("invalid flag not a pulse");
  chk_inv_no_act: assert property (SHOT_INVALID |-> !ACTIVITY)
    else $error("restart without holdoff");
  chk_shot_len: assert property (ACTIVITY |=> !SHOT_INVALID [*8])
    else $error("shot ended too early");
  chk_rd_answer: assert property (RDATA != '0 |-> $past(RD))
    else $error("read data without read");
endmodule
bind scope_shot_trigger_control scope_trig_monitor scope_trig_monitor_i (
  .CORE_CLK, .NRST, .WR, .RD, .RDATA, .ACTIVITY, .SHOT_INVALID, .ACQ_ON
);
`default_nettype wire

// >>> src_model.sv
`timescale 1ns/100ps
`default_nettype none
module src_model
  import scope_trig_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] hi,
  input wire sample_t hv,
  input wire sample_t lv,
  output analog_src_s an,
  output logic [1:0] dl,
  output sample_t sd
);
  // source index bit high drives that source above, else below
  always_comb begin
    for (int i = 0; i < 2; i++) an.sig_in[i] = hi[2+i] ? hv : lv;
    for (int i = 0; i < 2; i++) an.sig_out[i] = hi[4+i] ? hv : lv;
    for (int i = 0; i < 8; i++) an.osc[i] = hi[6+i] ? hv : lv;
    dl = hi[15:14];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sd <= 16'sh0000;
    else sd <= sd + 16'sh0001;
  end
endmodule
`default_nettype wire

// >>> scope_shot_trigger_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module scope_shot_trigger_control_tb
  import scope_trig_pkg::*;
;
  logic clk, rst_n, wr_s, rd_s, ready, sv, act, inv, acq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] mask;
  logic [1:0] dl;
  sample_t hv, lv, sd;
  analog_src_s an;
  shot_word_s sw;
  int n_errors = 0, n_tests = 0, n_act = 0, n_inv = 0, n_words = 0, n_last = 0, cyc = 0;

  scope_shot_trigger_control scope_shot_trigger_control_i (
    .CORE_CLK(clk), .NRST(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .ANALOG(an), .SRC_VALID(1'b1),
    .DIGITAL_LINE(dl), .SCOPE_DATA(sd), .SCOPE_VALID(1'b1), .SHOT_DATA(sw),
    .SHOT_VALID(sv), .SHOT_READY(ready), .ACTIVITY(act),
    .SHOT_INVALID(inv), .ACQ_ON(acq)
  );
  src_model src_model_i (
    .clk(clk), .nrst(rst_n), .hi(mask), .hv(hv), .lv(lv), .an(an), .dl(dl), .sd(sd)
  );

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (act === 1'b1) n_act <= n_act + 1;
    if (inv === 1'b1) n_inv <= n_inv + 1;
    if (sv === 1'b1 && ready) begin
      n_words <= n_words + 1;
      if (sw.last === 1'b1) n_last <= n_last + 1;
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_for(ref int c, input int k, input int lim);
    for (int i = 0; i < lim && c < k; i++) @(posedge clk);
    if (c < k) begin
      n_errors++;
      $display("CHECK FAILED wait exp %0d got %0d", k, c);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask

  task automatic off();
    wr(OFS_CTRL, 32'h0);
    repeat (20) @(posedge clk);
  endtask

  task automatic t_reset();
    rchk(OFS_CTRL, 32'h10);
    rchk(OFS_LEVEL, 32'h0);
    rchk(OFS_HOLDOFF, 32'(HOLD_RST_CYC));
    rchk(OFS_AVG_COUNT, 32'h0);
    rchk(8'h1c, 32'h0);
    repeat (40) @(posedge clk);
    rchk(OFS_SHOT_COUNT, 32'h0);
    `CHK("acq", 1'b0, acq)
  endtask

  task automatic t_cont();
    int t1, t2, t3;
    wr(OFS_HOLDOFF, 32'h2);
    wr(OFS_CTRL, 32'h11);
    wait_for(n_act, 1, 60);
    t1 = cyc;
    wait_for(n_act, 2, 60);
    t2 = cyc;
    wr(OFS_HOLDOFF, 32'ha);
    wait_for(n_act, 3, 60);
    t3 = cyc;
    `CHK("gap", 8, (t3 - t2) - (t2 - t1))
    wait_for(n_last, 3, 40);
    off();
    `CHK("words", 3 * SHOT_LEN, n_words)
    `CHK("after off", 3, n_act)
    rchk(OFS_SHOT_COUNT, 32'h3);
    rchk(OFS_AVG_COUNT, 32'h3);
    wr(OFS_CTRL, 32'h100);
    rchk(OFS_AVG_COUNT, 32'h0);
  endtask

  task automatic t_trig_off();
    mask <= 16'h0;
    wr(OFS_CTRL, 32'h12);
    wait_for(n_act, 4, 40);
    off();
  endtask

  task automatic t_src();
    int k;
    for (int s = 2; s < 16; s++) begin
      k = n_act;
      mask <= 16'hffff;
      wr(OFS_CTRL, 32'h30 | 32'(s));
      repeat (8) @(posedge clk);
      mask <= 16'h0;
      repeat (8) @(posedge clk);
      mask <= ~(16'h1 << s);
      repeat (8) @(posedge clk);
      `CHK("no trig", k, n_act)
      mask <= 16'hffff;
      wait_for(n_act, k + 1, 12);
      `CHK("trig", k + 1, n_act)
      off();
    end
  endtask

  task automatic t_neg();
    int k;
    wr(OFS_LEVEL, 32'hf6);
    rchk(OFS_LEVEL, 32'hfffffff6);
    hv <= 16'shfc18;
    lv <= 16'shec78;
    k = n_act;
    wr(OFS_CTRL, 32'h22);
    repeat (8) @(posedge clk);
    `CHK("neg idle", k, n_act)
    mask <= 16'h0;
    wait_for(n_act, k + 1, 12);
    `CHK("falling", k + 1, n_act)
    off();
  endtask

  task automatic t_loss();
    int k;
    ready <= 1'b0;
    wr(OFS_HOLDOFF, 32'hc8);
    k = n_words;
    wr(OFS_CTRL, 32'h11);
    wait_for(n_inv, 1, 80);
    `CHK("held", 1'b1, sv)
    off();
    ready <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("drained", k + FIFO_DEPTH, n_words)
    `CHK("empty", 1'b0, sv)
    rchk(OFS_LOST_COUNT, 32'h1);
    rchk(OFS_AVG_COUNT, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ready = 1'b1;
    mask = 16'hffff;
    hv = 16'sh0064;
    lv = 16'shff9c;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cont();
    t_trig_off();
    t_src();
    t_neg();
    t_loss();
    tally_and_finish();
  end
endmodule
`default_nettype wire
